// [shared/pb_map.svh]
// Purpose: Offsets, bit positions, reset values and timing of pb_ctrl
// Assumes: Included by bare name; definitions only
// Notes:   Millisecond figures count ticks of the 1 ms time base
`ifndef PB_MAP_SVH
`define PB_MAP_SVH
// Register byte offsets
`define PB_FLAG_OFS    8'h00
`define PB_MASK_OFS    8'h04
`define PB_SENSE_OFS   8'h08
`define PB_CTRL_OFS    8'h0C
// Flag and mask bit positions
`define PB_PUSH_BIT    0
`define PB_REL_BIT     1
`define PB_H1_BIT      2
`define PB_FLAG_W      7
// Sense bit positions
`define PB_SNS_BTN_BIT 0
`define PB_SNS_STB_BIT 1
`define PB_SNS_ON_BIT  2
// Reset values
`define PB_MASK_RST    7'h7F
`define PB_FLAG_RST    7'h00
// Clock and time base
`define PB_CLK_MHZ     250
`define PB_TICK_US     1000
`define PB_DISCH_US    30
// Debounce times in ms
`define PB_DB_SHORT_MS 10'h020
`define PB_DB_MID_MS   10'h07D
`define PB_DB_LONG_MS  10'h2EE
`define PB_DB_RISE_MS  10'h020
// Held-duration thresholds in ms
`define PB_H1S_MS      15'h03E8
`define PB_H2S_MS      15'h07D0
`define PB_H3S_MS      15'h0BB8
`define PB_H4S_MS      15'h0FA0
`define PB_H8S_MS      15'h1F40
`define PB_H16S_MS     15'h3E80
`endif

// [shared/pb_pkg.sv]
// Purpose: Types shared by the power button control block
// Assumes: Used together with pb_map.svh
// Notes:   Field order of ctrl_type is the control register layout
package pb_pkg;
    // Power state, Gray coded along off-on-down-discharge
    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_ON    = 2'b01,
        ST_DOWN  = 2'b11,
        ST_DISCH = 2'b10
    } pwr_state_type;
    // One APB request as seen by the slave
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } apb_req_type;
    // Control register, bit 5 down to bit 0
    typedef struct packed {
        logic       pol_inv;
        logic       rst_en;
        logic [1:0] dly_sel;
        logic [1:0] dbnc_sel;
    } ctrl_type;
endpackage

// [rtl/pb_ctrl.sv]
// Purpose: Power button, long press and standby request control
// Assumes: Pins synchronous to clk_sys_i; APB slave with 32-bit data
// Notes:   Debounce, held and long-press timers share a 1 ms tick
// Functional notes
// - Fuse 0: low level holds device off
// - Fuse 1: push button, press is low
// - Sense bit reads inverted pin level
// - Falling debounce by select, rising 32 ms
// - Debounce select loads from OTP at power-up
// - Debounced press powers on from off, raises flags only when on
// - Stable low in system-on sets push flag
// - Stable high after press sets release flag
// - Held low 1,2,3,4,8 s sets flags
// - Reset: power down, 30 us, power up
// - Long press without enable turns device off
// - Long press delay 2, 4, 8, 16 s
// - Long press select loads from OTP
// - Standby while on and effective request is asserted
// - Effective request is pin XOR invert bit
// - Flags latch, readable, cleared by writing one
// - Mask one keeps flag off interrupt pin
`timescale 1ns/1ps
`default_nettype none
`include "pb_map.svh"
module pb_ctrl
    import pb_pkg::*;
#(
    parameter int TICK_CYCLES  = `PB_TICK_US * `PB_CLK_MHZ,
    parameter int DISCH_CYCLES = `PB_DISCH_US * `PB_CLK_MHZ
) (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Pins and fuses
    input  wire logic        power_button_input_i,
    input  wire logic        standby_req_i,
    input  wire logic        button_mode_fuse_i,
    input  wire logic [1:0]  otp_dbnc_sel_i,
    input  wire logic [1:0]  otp_dly_sel_i,
    // Power sequencer handshake
    input  wire logic        pwr_down_done_i,
    output logic             pwr_down_o,
    output logic             sys_on_o,
    output logic             standby_o,
    // Interrupt, active high
    output logic             interrupt_output_pin_o
);
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int DW = $clog2(DISCH_CYCLES + 1);
    localparam int FW = `PB_FLAG_W;
    logic              rstn_meta_ff;  // First reset stage
    logic              rstn_sync_ff;  // Released reset for the block
    logic [TW-1:0]     tick_cnt_ff;   // Time base divider
    logic              tick;          // One cycle per ms
    logic              filt_ff;       // Debounced pin level
    logic [9:0]        deb_cnt_ff;    // Debounce tick count
    logic [9:0]        fall_lim;      // Falling edge debounce
    logic [9:0]        deb_lim;       // Active debounce limit
    logic              differ;        // Pin differs from filtered
    logic              flip;          // Filtered level changes
    logic              fell;          // Debounced press
    logic              rose;          // Debounced release
    logic [14:0]       held_cnt_ff;   // Ms held low
    logic [14:0]       dly_lim;       // Long press limit
    logic [4:0]        held_set;      // Held thresholds reached
    logic              long_hit;      // Long press expired
    logic              pressed_ff;    // Push seen, release pending
    logic              sense_ff;      // Inverted pin level
    pwr_state_type     state_ff;      // Power state
    pwr_state_type     nxt_state;     // Next power state
    logic              rst_pend_ff;   // Power down ends in reset
    logic              nxt_rst_pend;  // Next reset pending
    logic [DW-1:0]     disch_cnt_ff;  // Discharge wait count
    logic              disch_done;    // Discharge wait over
    logic              sys_on;        // System-on state
    logic              loaded_ff;     // OTP defaults taken
    logic              otp_load;      // Load OTP defaults now
    ctrl_type          ctrl_ff;       // Control register
    logic [FW-1:0]     flag_ff;       // Sticky event flags
    logic [FW-1:0]     mask_ff;       // Interrupt mask
    logic [FW-1:0]     flag_set;      // Events this cycle
    logic [FW-1:0]     flag_clr;      // Software clears
    logic              standby_ff;    // Standby output
    logic              sys_on_ff;     // System-on output
    logic              pwr_down_ff;   // Power down output
    logic              irq_ff;        // Interrupt output
    apb_req_type       req;           // Bundled APB request
    logic              ack_ff;        // APB ready
    logic              err_ff;        // APB error
    logic [31:0]       rdata_ff;      // APB read data
    logic              acc;           // Access phase
    logic              wr_en;         // Write completes
    logic              hit_flag;      // Flag register hit
    logic              hit_mask;      // Mask register hit
    logic              hit_sense;     // Sense register hit
    logic              hit_ctrl;      // Control register hit
    logic              addr_ok;       // Mapped address
    logic [31:0]       rd_val;        // Selected read value
    // Two-stage reset release
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rstn_meta_ff <= 1'b0;
            rstn_sync_ff <= 1'b0;
        end else begin
            rstn_meta_ff <= 1'b1;
            rstn_sync_ff <= rstn_meta_ff;
        end
    end
    // Free-running 1 ms time base shared by the debounce, held and long-press timers
    assign tick = (tick_cnt_ff == TW'(TICK_CYCLES - 1));
    always_ff @(posedge clk_sys_i or negedge rstn_sync_ff) begin
        if (!rstn_sync_ff) begin
            tick_cnt_ff <= '0;
        end else begin
            tick_cnt_ff <= tick ? '0 : tick_cnt_ff + TW'(1);
        end
    end
    // Debounce limits by select code and edge direction
    assign fall_lim = ctrl_ff.dbnc_sel == 2'h3 ? `PB_DB_LONG_MS :
                      ctrl_ff.dbnc_sel == 2'h2 ? `PB_DB_MID_MS :
                      `PB_DB_SHORT_MS;
    assign deb_lim  = filt_ff ? fall_lim : `PB_DB_RISE_MS;
    assign differ   = power_button_input_i ^ filt_ff;
    assign flip     = differ & tick & (deb_cnt_ff == deb_lim - 10'h001);
    assign fell     = flip & filt_ff;
    assign rose     = flip & ~filt_ff;
    // Filtered level; a bounce back restarts the count
    always_ff @(posedge clk_sys_i or negedge rstn_sync_ff) begin
        if (!rstn_sync_ff) begin
            filt_ff    <= 1'b1;
            deb_cnt_ff <= '0;
        end else if (!differ) begin
            deb_cnt_ff <= '0;
        end else if (flip) begin
            deb_cnt_ff <= '0;
            filt_ff    <= power_button_input_i;
        end else if (tick) begin
            deb_cnt_ff <= deb_cnt_ff + 10'h001;
        end
    end
    // Held-low time, saturates so it never wraps into a new event
    always_ff @(posedge clk_sys_i or negedge rstn_sync_ff) begin
        if (!rstn_sync_ff) begin
            held_cnt_ff <= '0;
        end else if (flip) begin
            held_cnt_ff <= '0;
        end else if (tick && !filt_ff && held_cnt_ff != '1) begin
            held_cnt_ff <= held_cnt_ff + 15'h0001;
        end
    end
    // Threshold crossings, each seen once per press
    assign held_set[0] = tick & ~filt_ff & (held_cnt_ff == `PB_H1S_MS - 15'h0001);
    assign held_set[1] = tick & ~filt_ff & (held_cnt_ff == `PB_H2S_MS - 15'h0001);
    assign held_set[2] = tick & ~filt_ff & (held_cnt_ff == `PB_H3S_MS - 15'h0001);
    assign held_set[3] = tick & ~filt_ff & (held_cnt_ff == `PB_H4S_MS - 15'h0001);
    assign held_set[4] = tick & ~filt_ff & (held_cnt_ff == `PB_H8S_MS - 15'h0001);
    // Long press delay by select code
    assign dly_lim = ctrl_ff.dly_sel == 2'h3 ? `PB_H16S_MS :
                     ctrl_ff.dly_sel == 2'h2 ? `PB_H8S_MS :
                     ctrl_ff.dly_sel == 2'h1 ? `PB_H4S_MS :
                     `PB_H2S_MS;
    // Only a push button has a long press; level mode is off when low
    assign long_hit = sys_on & button_mode_fuse_i & tick & ~filt_ff &
                      (held_cnt_ff == dly_lim - 15'h0001);
    assign sys_on     = (state_ff == ST_ON);
    assign disch_done = (disch_cnt_ff == DW'(DISCH_CYCLES - 1));
    // Power state selection
    always_comb begin
        nxt_state    = state_ff;
        nxt_rst_pend = rst_pend_ff;
        case (state_ff)
            ST_OFF: begin
                // Level mode needs high; push mode needs a press
                if (!button_mode_fuse_i && filt_ff && !differ) begin
                    nxt_state = ST_ON;
                end else if (button_mode_fuse_i && fell) begin
                    nxt_state = ST_ON;
                end
            end
            ST_ON: begin
                if (!button_mode_fuse_i && !filt_ff) begin
                    nxt_state    = ST_DOWN;
                    nxt_rst_pend = 1'b0;
                end else if (long_hit) begin
                    nxt_state    = ST_DOWN;
                    nxt_rst_pend = ctrl_ff.rst_en;
                end
            end
            ST_DOWN: begin
                // Sequencer reports the supplies are down
                if (pwr_down_done_i) begin
                    nxt_state = rst_pend_ff ? ST_DISCH : ST_OFF;
                end
            end
            ST_DISCH: begin
                // Supplies discharge, then power up again
                if (disch_done) begin
                    nxt_state    = ST_ON;
                    nxt_rst_pend = 1'b0;
                end
            end
            default: begin
                nxt_state    = ST_OFF;
                nxt_rst_pend = 1'b0;
            end
        endcase
    end
    // State register and registered state outputs
    always_ff @(posedge clk_sys_i or negedge rstn_sync_ff) begin
        if (!rstn_sync_ff) begin
            state_ff    <= ST_OFF;
            rst_pend_ff <= 1'b0;
            sys_on_ff   <= 1'b0;
            pwr_down_ff <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            rst_pend_ff <= nxt_rst_pend;
            sys_on_ff   <= (nxt_state == ST_ON);
            pwr_down_ff <= (nxt_state == ST_DOWN);
        end
    end
    // Discharge wait counts only inside its state
    always_ff @(posedge clk_sys_i or negedge rstn_sync_ff) begin
        if (!rstn_sync_ff) begin
            disch_cnt_ff <= '0;
        end else if (state_ff != ST_DISCH || disch_done) begin
            disch_cnt_ff <= '0;
        end else begin
            disch_cnt_ff <= disch_cnt_ff + DW'(1);
        end
    end
    // Standby while on, sense, and a release needing a push in ON
    always_ff @(posedge clk_sys_i or negedge rstn_sync_ff) begin
        if (!rstn_sync_ff) begin
            standby_ff <= 1'b0;
            sense_ff   <= 1'b0;
            pressed_ff <= 1'b0;
        end else begin
            standby_ff <= sys_on & (standby_req_i ^ ctrl_ff.pol_inv);
            sense_ff   <= ~power_button_input_i;
            if (fell && sys_on) begin
                pressed_ff <= 1'b1;
            end else if (rose) begin
                pressed_ff <= 1'b0;
            end
        end
    end
    // Events, only reported in system-on
    assign flag_set = {held_set & {5{sys_on}},
                       rose & sys_on & pressed_ff,
                       fell & sys_on};
    // APB request bundle and decode
    assign req       = '{sel: psel_i, enable: penable_i, write: pwrite_i,
                         addr: paddr_i, wdata: pwdata_i};
    assign acc       = req.sel & req.enable;
    assign wr_en     = acc & ack_ff & req.write;
    assign hit_flag  = (req.addr == `PB_FLAG_OFS);
    assign hit_mask  = (req.addr == `PB_MASK_OFS);
    assign hit_sense = (req.addr == `PB_SENSE_OFS);
    assign hit_ctrl  = (req.addr == `PB_CTRL_OFS);
    assign addr_ok   = hit_flag | hit_mask | hit_sense | hit_ctrl;
    assign flag_clr  = (wr_en && hit_flag) ? req.wdata[FW-1:0] : '0;
    assign otp_load  = ~loaded_ff | (state_ff == ST_DISCH && disch_done);
    assign rd_val    = hit_flag  ? {25'h0000000, flag_ff} :
                       hit_mask  ? {25'h0000000, mask_ff} :
                       hit_sense ? {29'h00000000, sys_on_ff, standby_ff, sense_ff} :
                       hit_ctrl  ? {26'h0000000, ctrl_ff} :
                       32'h00000000;
    // APB handshake: one wait state so read data comes from a flop
    always_ff @(posedge clk_sys_i or negedge rstn_sync_ff) begin
        if (!rstn_sync_ff) begin
            ack_ff   <= 1'b0;
            err_ff   <= 1'b0;
            rdata_ff <= '0;
        end else begin
            ack_ff <= acc & ~ack_ff;
            err_ff <= acc & ~ack_ff & ~addr_ok;
            if (acc && !ack_ff) begin
                rdata_ff <= req.write ? 32'h00000000 : rd_val;
            end
        end
    end
    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge clk_sys_i or negedge rstn_sync_ff) begin
        if (!rstn_sync_ff) begin
            flag_ff <= `PB_FLAG_RST;
        end else begin
            flag_ff <= (flag_ff & ~flag_clr) | flag_set;
        end
    end
    // Mask and control; OTP defaults override a same-cycle write
    always_ff @(posedge clk_sys_i or negedge rstn_sync_ff) begin
        if (!rstn_sync_ff) begin
            mask_ff   <= `PB_MASK_RST;
            ctrl_ff   <= '0;
            loaded_ff <= 1'b0;
        end else begin
            loaded_ff <= 1'b1;
            if (wr_en && hit_mask) begin
                mask_ff <= req.wdata[FW-1:0];
            end
            if (otp_load) begin
                ctrl_ff <= '{pol_inv: 1'b0, rst_en: 1'b0,
                             dly_sel: otp_dly_sel_i,
                             dbnc_sel: otp_dbnc_sel_i};
            end else if (wr_en && hit_ctrl) begin
                ctrl_ff <= ctrl_type'(req.wdata[5:0]);
            end
        end
    end
    // Interrupt pin: any unmasked flag, one cycle behind the flags
    always_ff @(posedge clk_sys_i or negedge rstn_sync_ff) begin
        if (!rstn_sync_ff) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(flag_ff & ~mask_ff);
        end
    end
    assign prdata_o               = rdata_ff;
    assign pready_o               = ack_ff;
    assign pslverr_o              = err_ff;
    assign pwr_down_o             = pwr_down_ff;
    assign sys_on_o               = sys_on_ff;
    assign standby_o              = standby_ff;
    assign interrupt_output_pin_o = irq_ff;
    // Checks on the block's own behaviour
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_sync_ff);
    sequence s_release;
        pressed_ff ##0 (rose && sys_on);
    endsequence
    sequence s_disch_end;
        (state_ff == ST_DISCH) ##1 (state_ff == ST_ON);
    endsequence
    property p_level_off;
        (sys_on && !button_mode_fuse_i && !filt_ff) |=> state_ff == ST_DOWN;
    endproperty
    a_level_off: assert property (p_level_off) else $error("level low not off");
    property p_sense;
        1'b1 |=> sense_ff == !$past(power_button_input_i);
    endproperty
    a_sense: assert property (p_sense) else $error("sense bit wrong");
    property p_fall;
        $fell(filt_ff) |-> $past(tick && deb_cnt_ff == fall_lim - 10'h001);
    endproperty
    a_fall: assert property (p_fall) else $error("falling debounce wrong");
    property p_rise;
        $rose(filt_ff) |-> $past(tick && deb_cnt_ff == `PB_DB_RISE_MS - 10'h001);
    endproperty
    a_rise: assert property (p_rise) else $error("rising debounce wrong");
    property p_otp;
        otp_load && rstn_sync_ff |=>
            ctrl_ff == {2'b00, $past(otp_dly_sel_i), $past(otp_dbnc_sel_i)};
    endproperty
    a_otp: assert property (p_otp) else $error("OTP default not loaded");
    property p_push;
        (fell && sys_on) |=> flag_ff[`PB_PUSH_BIT];
    endproperty
    a_push: assert property (p_push) else $error("push flag missing");
    property p_rel;
        s_release |=> flag_ff[`PB_REL_BIT];
    endproperty
    a_rel: assert property (p_rel) else $error("release flag missing");
    property p_held;
        (held_set[0] && sys_on) |=> flag_ff[`PB_H1_BIT];
    endproperty
    a_held: assert property (p_held) else $error("held flag missing");
    property p_long;
        long_hit |=> state_ff == ST_DOWN && rst_pend_ff == $past(ctrl_ff.rst_en);
    endproperty
    a_long: assert property (p_long) else $error("long press ignored");
    property p_disch;
        s_disch_end |-> $past(disch_cnt_ff, 1) == DW'(DISCH_CYCLES - 1);
    endproperty
    a_disch: assert property (p_disch) else $error("discharge wait wrong");
    property p_stby;
        1'b1 |=> standby_o == $past(sys_on && (standby_req_i ^ ctrl_ff.pol_inv));
    endproperty
    a_stby: assert property (p_stby) else $error("standby wrong");
    property p_w1c;
        1'b1 |=> (flag_ff & $past(flag_ff & ~flag_clr)) == $past(flag_ff & ~flag_clr);
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag lost");
    property p_mask;
        ((flag_ff & ~mask_ff) == '0) [*2] |=> !interrupt_output_pin_o;
    endproperty
    a_mask: assert property (p_mask) else $error("masked flag drives pin");
endmodule
`default_nettype wire

// [tb/pb_seq_model.sv]
// Purpose: Power sequencer stand-in that answers the power-down request
// Assumes: pwr_down_i is registered and synchronous to clk_sys_i
// Notes:   Fixed answer delay; counts each power-down request seen
`timescale 1ns/1ps
`default_nettype none
module pb_seq_model #(
    parameter int DONE_DLY = 6  // Cycles until the sequence is over
) (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    // Sequencer handshake
    input  wire logic       pwr_down_i,
    output logic            pwr_down_done_o,
    output logic [7:0]      down_count_o
);
    logic [7:0] wait_ff;  // Cycles spent in the current power down
    // Done rises after the delay and falls with the request
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_ff <= 8'h00;
            pwr_down_done_o <= 1'b0;
            down_count_o <= 8'h00;
        end else if (pwr_down_i) begin
            // Counting the first cycle only, so one request counts once
            if (wait_ff == 8'h00) begin
                down_count_o <= down_count_o + 8'h01;
            end
            wait_ff <= wait_ff + 8'h01;
            pwr_down_done_o <= (wait_ff >= 8'(DONE_DLY));
        end else begin
            wait_ff <= 8'h00;
            pwr_down_done_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [tb/power_button_standby_control_bench.sv]
// Purpose: Self-checking bench of pb_ctrl over APB and its pins
// Assumes: Short tick (4 cycles) and short discharge (8 cycles)
// Notes:   Timing checks allow two ticks of slack for tick phase
`timescale 1ns/1ps
`default_nettype none
`include "pb_map.svh"
module power_button_standby_control_bench;
    import pb_pkg::*;
    localparam int TCK = 4;  // Clock cycles per time base tick
    logic clk_sys_i, rstn_i, psel, pen, pwrite, pin, stby, fuse, done;
    logic [7:0] paddr, downs;
    logic [31:0] pwdata, prdata_o, seed;
    logic [1:0] otp_db, otp_dly;
    logic pready_o, pslverr_o, pwr_down_o, sys_on_o, standby_o, irq;
    int errors, check_count, cyc;
    pb_ctrl #(.TICK_CYCLES(TCK), .DISCH_CYCLES(8)) i_dut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .power_button_input_i(pin),
        .standby_req_i(stby), .button_mode_fuse_i(fuse),
        .otp_dbnc_sel_i(otp_db), .otp_dly_sel_i(otp_dly),
        .pwr_down_done_i(done), .pwr_down_o(pwr_down_o),
        .sys_on_o(sys_on_o), .standby_o(standby_o),
        .interrupt_output_pin_o(irq));
    pb_seq_model i_seq (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .pwr_down_i(pwr_down_o), .pwr_down_done_o(done),
        .down_count_o(downs));
    // Free running clock, 4 ns period
    always #2 clk_sys_i = ~clk_sys_i;
    // Hang guard, well above the expected run length
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 90000) begin
            errors++;
            print_verdict();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Falling debounce in ticks for a select code
    function automatic int db_ms(input logic [1:0] c);
        return (c == 2'b11) ? `PB_DB_LONG_MS :
               (c == 2'b10) ? `PB_DB_MID_MS : `PB_DB_SHORT_MS;
    endfunction
    task automatic print_verdict();
        if (errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask
    task automatic wait_ticks(input int n);
        repeat (n * TCK) @(posedge clk_sys_i);
    endtask
    // One APB transfer; entered and left just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [32:0] re);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        pen <= 1'b1;
        do begin
            @(posedge clk_sys_i);
        end while (pready_o !== 1'b1);
        re = {pslverr_o, prdata_o};
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] re;
        apb(1'b1, a, d, re);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] exp);
        logic [32:0] re;
        apb(1'b0, a, 32'h0, re);
        chk(re, exp);
    endtask
    initial begin
        {clk_sys_i, rstn_i, psel, pen, pwrite, stby, cyc} = '0;
        {paddr, pwdata, errors, check_count} = '0;
        {pin, fuse, otp_db, otp_dly, seed} = {1'b1, 1'b1, 2'b10, 2'b00, 32'h0000003A};
        repeat (12) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        rd(`PB_MASK_OFS, 33'h7F);
        rd(`PB_CTRL_OFS, 33'h02);
        rd(8'h10, 33'h100000000);
        chk(sys_on_o, 1'b0);
        pin <= 1'b0;
        wait_ticks(140);
        rd(`PB_SENSE_OFS, 33'h5);
        pin <= 1'b1;
        wait_ticks(40);
        wr(`PB_FLAG_OFS, 32'h7F);
        wr(`PB_MASK_OFS, 32'h0);
        // Each debounce code: press and release edges, then W1C
        for (int c = 0; c < 4; c++) begin
            wr(`PB_CTRL_OFS, 32'h0C | c);
            pin <= 1'b0;
            wait_ticks(db_ms(c[1:0]) - 3);
            rd(`PB_FLAG_OFS, 33'h0);
            wait_ticks(5);
            rd(`PB_FLAG_OFS, 33'h1);
            chk(irq, 1'b1);
            pin <= 1'b1;
            wait_ticks(`PB_DB_RISE_MS - 3);
            rd(`PB_FLAG_OFS, 33'h1);
            wait_ticks(5);
            rd(`PB_FLAG_OFS, 33'h3);
            wr(`PB_FLAG_OFS, 32'h1);
            rd(`PB_FLAG_OFS, 33'h2);
            wr(`PB_FLAG_OFS, 32'h2);
            @(posedge clk_sys_i);
            chk(irq, 1'b0);
        end
        // Held-duration flags under a full mask, 32 ms debounce
        wr(`PB_MASK_OFS, 32'h7F);
        wr(`PB_CTRL_OFS, 32'h0C);
        pin <= 1'b0;
        wait_ticks(1020);
        rd(`PB_FLAG_OFS, 33'h1);
        wait_ticks(20);
        rd(`PB_FLAG_OFS, 33'h5);
        wait_ticks(7010);
        rd(`PB_FLAG_OFS, 33'h7D);
        chk(irq, 1'b0);
        wr(`PB_MASK_OFS, 32'h7B);
        @(posedge clk_sys_i);
        chk(irq, 1'b1);
        wr(`PB_MASK_OFS, 32'h7F);
        pin <= 1'b1;
        wait_ticks(40);
        // Random standby pin and polarity
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            stby <= seed[0];
            wr(`PB_CTRL_OFS, {26'h0, seed[1], 5'h0C});
            @(posedge clk_sys_i);
            chk(standby_o, seed[0] ^ seed[1]);
        end
        stby <= 1'b0;
        // Long press of 2 s without reset turns off
        wr(`PB_CTRL_OFS, 32'h00);
        pin <= 1'b0;
        wait_ticks(2010);
        chk(sys_on_o, 1'b1);
        wait_ticks(40);
        chk({sys_on_o, downs}, 9'h001);
        pin <= 1'b1;
        wait_ticks(40);
        pin <= 1'b0;
        wait_ticks(40);
        chk(sys_on_o, 1'b1);
        // Long press of 4 s with reset: back on with OTP selects
        wr(`PB_CTRL_OFS, 32'h15);
        wait_ticks(3980);
        chk(downs, 8'h1);
        wait_ticks(40);
        chk({sys_on_o, downs}, 9'h102);
        rd(`PB_CTRL_OFS, 33'h02);
        // Second reset into level mode
        rstn_i <= 1'b0;
        fuse <= 1'b0;
        repeat (12) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        wait_ticks(40);
        chk(sys_on_o, 1'b0);
        pin <= 1'b1;
        wait_ticks(40);
        chk(sys_on_o, 1'b1);
        pin <= 1'b0;
        wait_ticks(140);
        chk({sys_on_o, downs}, 9'h001);
        print_verdict();
    end
endmodule
`default_nettype wire
